/* File: sse_exec_slice.sv */
// execution slice: subroutine return, stores, sign extends, right shifts, cache tag writes, exclusive-or
//
// Contract
// RULE1 - return loads program counter with first source plus sign-extended immediate, two cycles
// RULE2 - the instruction after a return always completes before the target is fetched
// RULE3 - byte store writes data bits 24-31 at sum address, no register changes
// RULE4 - halfword store clears address bit 31, writes data bits 16-31, marks store
// RULE5 - word store clears address bits 30-31, writes full data word, marks store
// RULE6 - halfword sign extend replicates source bit 16 into destination bits 0-15
// RULE7 - byte sign extend replicates source bit 24 into destination bits 0-23
// RULE8 - arithmetic shift right keeps sign bit, source bit 31 goes to carry
// RULE9 - carry shift right puts old carry in bit 0, bit 31 to carry
// RULE10 - logical shift right inserts zero at bit 0, bit 31 to carry
// RULE11 - data cache tag written from first source, bit 30 is valid
// RULE12 - software issues data cache tag write only with data cache disabled
// RULE13 - instruction cache tag written from first source, bit 30 is valid
// RULE14 - software issues instruction cache tag write only with instruction cache disabled
// RULE15 - register exclusive-or writes first source xor second source to destination
// RULE16 - immediate exclusive-or zero-extends the immediate, xors with first source
// RULE17 - bit 0 is the most significant bit of every word
`timescale 1ns/1ps
module sse_exec_slice (
  // clock, reset, enable
  input  wire  logic                   core_clk_in,
  input  wire  logic                   rst_in,
  input  wire  logic                   ce_in,
  // issue port from the core
  input  wire  logic                   issue_in,
  input  wire  sse_pkg::sse_op_t       op_in,
  input  wire  logic [0:31]            first_src_reg_in,
  input  wire  logic [0:31]            second_src_reg_in,
  input  wire  logic [0:31]            dest_data_reg_in,
  input  wire  logic [0:15]            immediate_field_in,
  // machine status flags from the core
  input  wire  logic                   carry_flag_in,
  input  wire  logic                   dcache_enable_flag_in,
  input  wire  logic                   icache_enable_flag_in,
  // register file write back
  output logic                         dest_we_out,
  output logic [0:31]                  dest_data_out,
  output logic                         carry_we_out,
  output logic                         carry_out,
  output logic                         store_flag_we_out,
  // data memory store port
  output logic                         mem_we_out,
  output logic [0:31]                  mem_addr_out,
  output logic [0:31]                  mem_wdata_out,
  output sse_pkg::sse_size_t           mem_size_out,
  // program counter load
  output logic                         pc_load_out,
  output logic [0:31]                  pc_target_out,
  output logic                         ret_pending_out,
  // cache tag write ports
  output logic                         dcache_tag_we_out,
  output logic                         icache_tag_we_out,
  output logic [0:31]                  cache_tag_out,
  output logic                         cache_tag_valid_out,
  output logic                         cache_misuse_out
);
  import sse_pkg::*;

  // RULE17 bit 0 msb
  // sign-extend the 16-bit immediate to a word
  function automatic logic [0:31] sse_sext_imm(input logic [0:15] immediate_field);
    sse_sext_imm = {{SSE_IMM_W{immediate_field[0]}}, immediate_field};
  endfunction : sse_sext_imm

  // store address: base plus register or sign-extended immediate
  function automatic logic [0:31] sse_store_addr(input logic [0:31] base, input logic [0:31] sec,
                                                 input logic [0:15] immediate_field, input logic use_imm);
    if (use_imm) begin
      sse_store_addr = base + sse_sext_imm(immediate_field);
    end else begin
      sse_store_addr = base + sec;
    end
  endfunction : sse_store_addr

  // registered state
  sse_state_t     state_ff;
  sse_state_t     nxt_state;
  logic           dest_we_ff;
  logic [0:31]    dest_data_ff;
  logic           carry_we_ff;
  logic           carry_ff;
  logic           store_flag_we_ff;
  logic           mem_we_ff;
  logic [0:31]    mem_addr_ff;
  logic [0:31]    mem_wdata_ff;
  sse_size_t      mem_size_ff;
  logic           pc_load_ff;
  logic [0:31]    pc_target_ff;
  logic           dc_tag_we_ff;
  logic           ic_tag_we_ff;
  logic [0:31]    tag_ff;
  logic           tag_valid_ff;
  logic           misuse_ff;

  // decoded issue qualifiers
  logic           go;
  logic           is_store;
  logic           store_imm;
  logic           is_ret;
  logic           is_alu;
  logic [0:31]    store_addr;

  assign go        = ce_in && issue_in;
  assign is_ret    = (op_in == SSE_OP_RET_SUBROUTINE);
  assign store_imm = (op_in == SSE_OP_STORE_BYTE_IMM) || (op_in == SSE_OP_STORE_HALF_IMM) ||
                     (op_in == SSE_OP_STORE_WORD_IMM);
  assign is_store  = store_imm || (op_in == SSE_OP_STORE_BYTE_REG) ||
                     (op_in == SSE_OP_STORE_HALF_REG) || (op_in == SSE_OP_STORE_WORD_REG);
  assign is_alu    = (op_in == SSE_OP_HALF_SIGN_EXTEND) || (op_in == SSE_OP_BYTE_SIGN_EXTEND) ||
                     (op_in == SSE_OP_ARITH_RIGHT_SHIFT) || (op_in == SSE_OP_CARRY_RIGHT_SHIFT) ||
                     (op_in == SSE_OP_LOGICAL_RIGHT_SHIFT) || (op_in == SSE_OP_REG_EXCLUSIVE_OR) ||
                     (op_in == SSE_OP_IMM_EXCLUSIVE_OR);
  assign store_addr = sse_store_addr(first_src_reg_in, second_src_reg_in, immediate_field_in, store_imm);

  // return sequencer: wait for the delay slot instruction before loading the counter
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SSE_ST_IDLE: begin
        if (go && is_ret) begin
          nxt_state = SSE_ST_WAIT_SLOT;
        end
      end
      // RULE2 slot completes first
      SSE_ST_WAIT_SLOT: begin
        if (go) begin
          nxt_state = SSE_ST_IDLE;
        end
      end
      default: begin
        nxt_state = SSE_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_ff <= SSE_ST_IDLE;
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // branch target capture and counter load pulse
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pc_target_ff <= SSE_WORD_RESET;
      pc_load_ff   <= 1'b0;
    end else if (ce_in) begin
      pc_load_ff <= 1'b0;
      // RULE1 target sum
      if (go && is_ret && (state_ff == SSE_ST_IDLE)) begin
        pc_target_ff <= first_src_reg_in + sse_sext_imm(immediate_field_in);
      end
      // RULE2 load after slot
      if (go && (state_ff == SSE_ST_WAIT_SLOT)) begin
        pc_load_ff <= 1'b1;
      end
    end
  end

  // store path towards data memory
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      mem_we_ff        <= 1'b0;
      mem_addr_ff      <= SSE_WORD_RESET;
      mem_wdata_ff     <= SSE_WORD_RESET;
      mem_size_ff      <= SSE_SIZE_WORD;
      store_flag_we_ff <= 1'b0;
    end else if (ce_in) begin
      mem_we_ff        <= go && is_store;
      store_flag_we_ff <= 1'b0;
      if (go) begin
        case (op_in)
          // RULE3 byte store
          SSE_OP_STORE_BYTE_REG, SSE_OP_STORE_BYTE_IMM: begin
            mem_addr_ff  <= store_addr;
            mem_wdata_ff <= {24'h00_0000, dest_data_reg_in[24:31]};
            mem_size_ff  <= SSE_SIZE_BYTE;
          end
          // RULE4 halfword store
          SSE_OP_STORE_HALF_REG, SSE_OP_STORE_HALF_IMM: begin
            mem_addr_ff      <= store_addr & SSE_HALF_ALIGN_MASK;
            mem_wdata_ff     <= {16'h0000, dest_data_reg_in[16:31]};
            mem_size_ff      <= SSE_SIZE_HALF;
            store_flag_we_ff <= 1'b1;
          end
          // RULE5 word store
          SSE_OP_STORE_WORD_REG, SSE_OP_STORE_WORD_IMM: begin
            mem_addr_ff      <= store_addr & SSE_WORD_ALIGN_MASK;
            mem_wdata_ff     <= dest_data_reg_in;
            mem_size_ff      <= SSE_SIZE_WORD;
            store_flag_we_ff <= 1'b1;
          end
          default: begin
            mem_addr_ff <= mem_addr_ff;
          end
        endcase
      end
    end
  end

  // destination register results and carry updates
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dest_we_ff   <= 1'b0;
      dest_data_ff <= SSE_WORD_RESET;
      carry_we_ff  <= 1'b0;
      carry_ff     <= 1'b0;
    end else if (ce_in) begin
      dest_we_ff  <= go && is_alu;
      carry_we_ff <= 1'b0;
      if (go) begin
        case (op_in)
          // RULE6 halfword extend
          SSE_OP_HALF_SIGN_EXTEND: begin
            dest_data_ff <= {{16{first_src_reg_in[SSE_HALF_SIGN_BIT]}}, first_src_reg_in[16:31]};
          end
          // RULE7 byte extend
          SSE_OP_BYTE_SIGN_EXTEND: begin
            dest_data_ff <= {{24{first_src_reg_in[SSE_BYTE_SIGN_BIT]}}, first_src_reg_in[24:31]};
          end
          // RULE8 arithmetic shift
          SSE_OP_ARITH_RIGHT_SHIFT: begin
            dest_data_ff <= {first_src_reg_in[SSE_MSB_BIT], first_src_reg_in[0:30]};
            carry_we_ff  <= 1'b1;
            carry_ff     <= first_src_reg_in[SSE_LSB_BIT];
          end
          // RULE9 shift through carry
          SSE_OP_CARRY_RIGHT_SHIFT: begin
            dest_data_ff <= {carry_flag_in, first_src_reg_in[0:30]};
            carry_we_ff  <= 1'b1;
            carry_ff     <= first_src_reg_in[SSE_LSB_BIT];
          end
          // RULE10 logical shift
          SSE_OP_LOGICAL_RIGHT_SHIFT: begin
            dest_data_ff <= {1'b0, first_src_reg_in[0:30]};
            carry_we_ff  <= 1'b1;
            carry_ff     <= first_src_reg_in[SSE_LSB_BIT];
          end
          // RULE15 register xor
          SSE_OP_REG_EXCLUSIVE_OR: begin
            dest_data_ff <= first_src_reg_in ^ second_src_reg_in;
          end
          // RULE16 zero-extended immediate xor
          SSE_OP_IMM_EXCLUSIVE_OR: begin
            dest_data_ff <= first_src_reg_in ^ {16'h0000, immediate_field_in};
          end
          default: begin
            dest_data_ff <= dest_data_ff;
          end
        endcase
      end
    end
  end

  // cache tag writes, second source deliberately unused
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dc_tag_we_ff <= 1'b0;
      ic_tag_we_ff <= 1'b0;
      tag_ff       <= SSE_WORD_RESET;
      tag_valid_ff <= 1'b0;
      misuse_ff    <= 1'b0;
    end else if (ce_in) begin
      // RULE11 data tag
      dc_tag_we_ff <= go && (op_in == SSE_OP_DCACHE_TAG_WRITE);
      // RULE13 instruction tag
      ic_tag_we_ff <= go && (op_in == SSE_OP_ICACHE_TAG_WRITE);
      // RULE12 RULE14 flag misuse
      misuse_ff <= go && (((op_in == SSE_OP_DCACHE_TAG_WRITE) && dcache_enable_flag_in) ||
                          ((op_in == SSE_OP_ICACHE_TAG_WRITE) && icache_enable_flag_in));
      if (go && ((op_in == SSE_OP_DCACHE_TAG_WRITE) || (op_in == SSE_OP_ICACHE_TAG_WRITE))) begin
        tag_ff       <= first_src_reg_in;
        tag_valid_ff <= first_src_reg_in[SSE_TAG_VALID_BIT];
      end
    end
  end

  // output drive
  assign dest_we_out         = dest_we_ff;
  assign dest_data_out       = dest_data_ff;
  assign carry_we_out        = carry_we_ff;
  assign carry_out           = carry_ff;
  assign store_flag_we_out   = store_flag_we_ff;
  assign mem_we_out          = mem_we_ff;
  assign mem_addr_out        = mem_addr_ff;
  assign mem_wdata_out       = mem_wdata_ff;
  assign mem_size_out        = mem_size_ff;
  assign pc_load_out         = pc_load_ff;
  assign pc_target_out       = pc_target_ff;
  assign ret_pending_out     = (state_ff == SSE_ST_WAIT_SLOT);
  assign dcache_tag_we_out   = dc_tag_we_ff;
  assign icache_tag_we_out   = ic_tag_we_ff;
  assign cache_tag_out       = tag_ff;
  assign cache_tag_valid_out = tag_valid_ff;
  assign cache_misuse_out    = misuse_ff;

  // checks on the return sequence
  ret_target_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE1
    (go && is_ret && state_ff == SSE_ST_IDLE) |=>
      (pc_target_out == $past(first_src_reg_in) + {{16{$past(immediate_field_in[0])}}, $past(immediate_field_in)}))
    else $error("return target is not base plus sign-extended immediate");

  ret_slot_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE2
    (go && is_ret && state_ff == SSE_ST_IDLE) |=> (!pc_load_out && ret_pending_out))
    else $error("counter loaded before delay slot completed");

  slot_load_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE2
    (go && ret_pending_out) |=> (pc_load_out && !ret_pending_out))
    else $error("counter not loaded after delay slot");

  ret_two_cycle_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE1
    (go && is_ret && state_ff == SSE_ST_IDLE) ##1 go |=> pc_load_out)
    else $error("return did not finish in two cycles");

  // checks on stores
  byte_store_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE3
    (go && op_in == SSE_OP_STORE_BYTE_REG) |=>
      (mem_we_out && mem_addr_out == $past(first_src_reg_in) + $past(second_src_reg_in) &&
       mem_wdata_out[24:31] == $past(dest_data_reg_in[24:31]) && !dest_we_out))
    else $error("byte store address or data wrong");

  half_align_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE4
    (go && (op_in == SSE_OP_STORE_HALF_REG || op_in == SSE_OP_STORE_HALF_IMM)) |=>
      (mem_addr_out[31] == 1'b0 && mem_wdata_out[16:31] == $past(dest_data_reg_in[16:31]) && store_flag_we_out))
    else $error("halfword store not aligned or data wrong");

  word_align_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE5
    (go && op_in == SSE_OP_STORE_WORD_IMM) |=>
      (mem_addr_out == (($past(first_src_reg_in) + {{16{$past(immediate_field_in[0])}},
       $past(immediate_field_in)}) & 32'hFFFF_FFFC) && mem_wdata_out == $past(dest_data_reg_in)))
    else $error("word store address or data wrong");

  // checks on register results and cache tag writes
  half_ext_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE6
    (go && op_in == SSE_OP_HALF_SIGN_EXTEND) |=>
      (dest_we_out && dest_data_out[0:15] == {16{$past(first_src_reg_in[16])}}))
    else $error("halfword sign extension wrong");

  byte_ext_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE7
    (go && op_in == SSE_OP_BYTE_SIGN_EXTEND) |=>
      (dest_data_out == {{24{$past(first_src_reg_in[24])}}, $past(first_src_reg_in[24:31])}))
    else $error("byte sign extension wrong");

  carry_shift_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE9
    (go && op_in == SSE_OP_CARRY_RIGHT_SHIFT) |=>
      (dest_data_out[0] == $past(carry_flag_in) && carry_we_out && carry_out == $past(first_src_reg_in[31])))
    else $error("shift through carry wrong");

  logic_shift_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE10
    (go && op_in == SSE_OP_LOGICAL_RIGHT_SHIFT) |=>
      (dest_data_out == {1'b0, $past(first_src_reg_in[0:30])} && carry_out == $past(first_src_reg_in[31])))
    else $error("logical shift wrong");

  arith_shift_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE8
    (go && op_in == SSE_OP_ARITH_RIGHT_SHIFT) |=>
      (dest_data_out[0:1] == {2{$past(first_src_reg_in[0])}} && carry_out == $past(first_src_reg_in[31])))
    else $error("arithmetic shift wrong");

  tag_valid_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE11
    (go && (op_in == SSE_OP_DCACHE_TAG_WRITE || op_in == SSE_OP_ICACHE_TAG_WRITE)) |=>
      (cache_tag_valid_out == $past(first_src_reg_in[30]) && (dcache_tag_we_out != icache_tag_we_out)))
    else $error("cache tag valid bit wrong");

  xor_imm_a: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE16
    (go && op_in == SSE_OP_IMM_EXCLUSIVE_OR) |=>
      (dest_data_out[0:15] == $past(first_src_reg_in[0:15])))
    else $error("immediate not zero-extended");

  // main scenarios
  ret_done_c: cover property (@(posedge core_clk_in) disable iff (rst_in) (go && is_ret) ##1 go ##1 pc_load_out);
  store_word_c: cover property (@(posedge core_clk_in) disable iff (rst_in) go && op_in == SSE_OP_STORE_WORD_REG);
  carry_chain_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
    (go && op_in == SSE_OP_CARRY_RIGHT_SHIFT) ##1 (go && op_in == SSE_OP_CARRY_RIGHT_SHIFT));
  tag_misuse_c: cover property (@(posedge core_clk_in) disable iff (rst_in) cache_misuse_out);

endmodule : sse_exec_slice

/* File: sse_mem_model.sv */
// data memory and cache tag arrays on the far side of the slice
`timescale 1ns/1ps
module sse_mem_model (
  // slice outputs
  input  wire logic               clk_in,
  input  wire logic               we_in,
  input  wire logic [0:31]        addr_in,
  input  wire logic [0:31]        wdata_in,
  input  wire sse_pkg::sse_size_t size_in,
  input  wire logic               dtag_we_in,
  input  wire logic               itag_we_in,
  input  wire logic [0:31]        tag_in,
  input  wire logic               valid_in,
  // bench readback
  input  wire logic [0:5]         rd_idx_in,
  output logic [0:31]             rd_data_out,
  output logic [0:32]             dtag_out,
  output logic [0:32]             itag_out
);
  import sse_pkg::*;
  logic [7:0] mem_ff [0:63];
  logic [0:5] i_w;
  assign i_w = addr_in[26:31];
  // lowest address holds bits 0-7 of a word
  always_ff @(posedge clk_in) begin
    if (we_in && size_in == SSE_SIZE_BYTE) begin
      mem_ff[i_w] <= wdata_in[24:31];
    end else if (we_in && size_in == SSE_SIZE_HALF) begin
      mem_ff[i_w]        <= wdata_in[16:23];
      mem_ff[i_w + 6'd1] <= wdata_in[24:31];
    end else if (we_in) begin
      mem_ff[i_w]        <= wdata_in[0:7];
      mem_ff[i_w + 6'd1] <= wdata_in[8:15];
      mem_ff[i_w + 6'd2] <= wdata_in[16:23];
      mem_ff[i_w + 6'd3] <= wdata_in[24:31];
    end
  end
  // tag arrays keep first source and its valid bit
  always_ff @(posedge clk_in) begin
    if (dtag_we_in) begin
      dtag_out <= {valid_in, tag_in};
    end
    if (itag_we_in) begin
      itag_out <= {valid_in, tag_in};
    end
  end
  // four bytes starting at the readback index
  assign rd_data_out = {mem_ff[rd_idx_in], mem_ff[rd_idx_in + 6'd1],
                        mem_ff[rd_idx_in + 6'd2], mem_ff[rd_idx_in + 6'd3]};
endmodule : sse_mem_model

/* File: sse_pkg.sv */
// shared constants and types for the store/shift/exclusive-or execution slice
package sse_pkg;

  // data path widths
  localparam int unsigned SSE_XLEN      = 32;
  localparam int unsigned SSE_IMM_W     = 16;

  // field positions, bit 0 is the most significant bit of a word
  localparam int unsigned SSE_TAG_VALID_BIT = 30;
  localparam int unsigned SSE_HALF_SIGN_BIT = 16;
  localparam int unsigned SSE_BYTE_SIGN_BIT = 24;
  localparam int unsigned SSE_MSB_BIT       = 0;
  localparam int unsigned SSE_LSB_BIT       = 31;

  // address alignment masks for halfword and word stores
  localparam logic [0:31] SSE_HALF_ALIGN_MASK = 32'hFFFF_FFFE;
  localparam logic [0:31] SSE_WORD_ALIGN_MASK = 32'hFFFF_FFFC;

  // reset values of the result registers
  localparam logic [0:31] SSE_WORD_RESET = 32'h0000_0000;

  // subroutine return takes this many cycles, its own and the delay slot
  localparam int unsigned SSE_RET_LATENCY = 2;

  // store access size codes
  typedef enum logic [1:0] {
    SSE_SIZE_BYTE = 2'h0,
    SSE_SIZE_HALF = 2'h1,
    SSE_SIZE_WORD = 2'h2
  } sse_size_t;

  // operations issued by the core to this slice
  typedef enum logic [4:0] {
    SSE_OP_NOP                 = 5'h00,
    SSE_OP_RET_SUBROUTINE      = 5'h01,
    SSE_OP_STORE_BYTE_REG      = 5'h02,
    SSE_OP_STORE_BYTE_IMM      = 5'h03,
    SSE_OP_STORE_HALF_REG      = 5'h04,
    SSE_OP_STORE_HALF_IMM      = 5'h05,
    SSE_OP_STORE_WORD_REG      = 5'h06,
    SSE_OP_STORE_WORD_IMM      = 5'h07,
    SSE_OP_HALF_SIGN_EXTEND    = 5'h08,
    SSE_OP_BYTE_SIGN_EXTEND    = 5'h09,
    SSE_OP_ARITH_RIGHT_SHIFT   = 5'h0A,
    SSE_OP_CARRY_RIGHT_SHIFT   = 5'h0B,
    SSE_OP_LOGICAL_RIGHT_SHIFT = 5'h0C,
    SSE_OP_DCACHE_TAG_WRITE    = 5'h0D,
    SSE_OP_ICACHE_TAG_WRITE    = 5'h0E,
    SSE_OP_REG_EXCLUSIVE_OR    = 5'h0F,
    SSE_OP_IMM_EXCLUSIVE_OR    = 5'h10
  } sse_op_t;

  // return sequencer states, one-hot
  typedef enum logic [1:0] {
    SSE_ST_IDLE      = 2'b01,
    SSE_ST_WAIT_SLOT = 2'b10
  } sse_state_t;

endpackage : sse_pkg

/* File: testbench.sv */
// self-checking bench for the store, shift and exclusive-or slice
`timescale 1ns/1ps
module testbench;
  import sse_pkg::*;
  // design inputs and bench operands
  logic        core_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, issue_in = 1'b0;
  logic        cin = 1'b0, dce = 1'b0, icache_enable_flag = 1'b0, tc, tdce, tice;
  sse_op_t     op_in = SSE_OP_NOP;
  logic [0:31] src_a = '0, src_b = '0, src_d = '0, ta, tb, td;
  logic [0:15] immediate_field = '0, ti;
  logic [0:5]  rd_idx = '0;
  // design and model outputs
  logic        dest_we, carry_we, carry_v, store_we, mem_we, pc_load, ret_pend, dtag_we, itag_we, t_valid, misuse;
  logic [0:31] dest_data, mem_addr, mem_wdata, pc_target, tag, rd_data;
  logic [0:32] dtag, itag;
  sse_size_t   mem_size;
  int          n_errors = 0, check_count = 0;
  // 50 MHz clock
  always #10 core_clk_in = ~core_clk_in;
  sse_exec_slice DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .issue_in(issue_in), .op_in(op_in),
    .first_src_reg_in(src_a), .second_src_reg_in(src_b), .dest_data_reg_in(src_d), .immediate_field_in(immediate_field),
    .carry_flag_in(cin), .dcache_enable_flag_in(dce), .icache_enable_flag_in(icache_enable_flag), .dest_we_out(dest_we),
    .dest_data_out(dest_data), .carry_we_out(carry_we), .carry_out(carry_v), .store_flag_we_out(store_we),
    .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_size_out(mem_size),
    .pc_load_out(pc_load), .pc_target_out(pc_target), .ret_pending_out(ret_pend), .dcache_tag_we_out(dtag_we),
    .icache_tag_we_out(itag_we), .cache_tag_out(tag), .cache_tag_valid_out(t_valid), .cache_misuse_out(misuse));
  sse_mem_model u_mem (.clk_in(core_clk_in), .we_in(mem_we), .addr_in(mem_addr), .wdata_in(mem_wdata),
    .size_in(mem_size), .dtag_we_in(dtag_we), .itag_we_in(itag_we), .tag_in(tag), .valid_in(t_valid),
    .rd_idx_in(rd_idx), .rd_data_out(rd_data), .dtag_out(dtag), .itag_out(itag));
  // compare and count
  task automatic chk(input string nm, input logic [0:32] exp, input logic [0:32] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // operands onto the issue port, called at a rising edge
  task automatic drive(input sse_op_t op);
    op_in <= op;
    src_a <= ta;
    src_b <= tb;
    src_d <= td;
    immediate_field   <= ti;
    cin   <= tc;
    dce   <= tdce;
    icache_enable_flag   <= tice;
  endtask : drive
  // one issued op, returns where its answer stands
  task automatic run_op(input sse_op_t op);
    @(posedge core_clk_in);
    drive(op);
    issue_in <= 1'b1;
    @(posedge core_clk_in);
    issue_in <= 1'b0;
    #1;
  endtask : run_op
  task automatic alu_chk(input sse_op_t op, input logic [0:31] exp, input logic cw, input logic c);
    run_op(op);
    chk("dest_we", 1, dest_we);
    chk("dest_data", exp, dest_data);
    chk("carry_we", cw, carry_we);
    if (cw) begin
      chk("carry", c, carry_v);
    end
  endtask : alu_chk
  // store port, no register write, then memory contents
  task automatic st_chk(input sse_op_t op, input logic [0:31] ad, input sse_size_t sz);
    logic [0:31] wd;
    int          sh;
    sh = (sz == SSE_SIZE_BYTE) ? 24 : (sz == SSE_SIZE_HALF) ? 16 : 0;
    wd = td & (32'hFFFF_FFFF >> sh);
    run_op(op);
    chk("mem_we", 1, mem_we);
    chk("mem_addr", ad, mem_addr);
    chk("mem_wdata", wd, mem_wdata);
    chk("mem_size", sz, mem_size);
    chk("store_flag_we", sz != SSE_SIZE_BYTE, store_we);
    chk("dest_we", 0, dest_we);
    rd_idx = ad[26:31];
    @(posedge core_clk_in);
    #1;
    chk("mem_model", wd << sh, rd_data & (32'hFFFF_FFFF << sh));
  endtask : st_chk
  // tag port and the tag array it reaches
  task automatic tg_chk(input sse_op_t op, input logic mis);
    logic is_d;
    is_d = (op == SSE_OP_DCACHE_TAG_WRITE);
    run_op(op);
    chk("dtag_we", is_d, dtag_we);
    chk("itag_we", !is_d, itag_we);
    chk("tag", ta, tag);
    chk("tag_valid", ta[30], t_valid);
    chk("misuse", mis, misuse);
    @(posedge core_clk_in);
    #1;
    chk("tag_array", {ta[30], ta}, is_d ? dtag : itag);
  endtask : tg_chk
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // watchdog
  initial begin
    #20_000;
    n_errors++;
    stop_test();
  end
  initial begin
    ta = 32'h8001_8081;
    tb = 32'h0F0F_F0F0;
    td = 32'hCAFE_BA5E;
    ti = 16'h8421;
    tdce = 1'b0;
    tice = 1'b0;
    repeat (20) @(posedge core_clk_in);
    rst_in <= 1'b0;
    #1;
    chk("mem_size", SSE_SIZE_WORD, mem_size);
    chk("ret_pending", 0, ret_pend);
    // every sign bit set, then every sign bit clear
    for (int k = 0; k < 2; k++) begin
      tc = k[0];
      alu_chk(SSE_OP_HALF_SIGN_EXTEND, {{16{ta[16]}}, ta[16:31]}, 0, 0);
      alu_chk(SSE_OP_BYTE_SIGN_EXTEND, {{24{ta[24]}}, ta[24:31]}, 0, 0);
      alu_chk(SSE_OP_ARITH_RIGHT_SHIFT, {ta[0], ta[0:30]}, 1, ta[31]);
      alu_chk(SSE_OP_CARRY_RIGHT_SHIFT, {tc, ta[0:30]}, 1, ta[31]);
      alu_chk(SSE_OP_LOGICAL_RIGHT_SHIFT, {1'b0, ta[0:30]}, 1, ta[31]);
      alu_chk(SSE_OP_REG_EXCLUSIVE_OR, ta ^ tb, 0, 0);
      alu_chk(SSE_OP_IMM_EXCLUSIVE_OR, ta ^ {16'h0000, ti}, 0, 0);
      ta = 32'h7FFE_7F7E;
    end
    // odd sums so alignment shows, negative immediate
    ta = 32'h0000_1003;
    tb = 32'h0000_0002;
    ti = 16'hFFFE;
    st_chk(SSE_OP_STORE_BYTE_REG, 32'h0000_1005, SSE_SIZE_BYTE);
    st_chk(SSE_OP_STORE_BYTE_IMM, 32'h0000_1001, SSE_SIZE_BYTE);
    st_chk(SSE_OP_STORE_HALF_REG, 32'h0000_1004, SSE_SIZE_HALF);
    st_chk(SSE_OP_STORE_HALF_IMM, 32'h0000_1000, SSE_SIZE_HALF);
    st_chk(SSE_OP_STORE_WORD_REG, 32'h0000_1004, SSE_SIZE_WORD);
    st_chk(SSE_OP_STORE_WORD_IMM, 32'h0000_1000, SSE_SIZE_WORD);
    // tag writes with caches off, then with caches on
    ta = 32'h1234_5672;
    tg_chk(SSE_OP_DCACHE_TAG_WRITE, 1'b0);
    ta = 32'h89AB_CDE1;
    tg_chk(SSE_OP_ICACHE_TAG_WRITE, 1'b0);
    tdce = 1'b1;
    tg_chk(SSE_OP_DCACHE_TAG_WRITE, 1'b1);
    tice = 1'b1;
    tg_chk(SSE_OP_ICACHE_TAG_WRITE, 1'b1);
    // a frozen slice ignores an issued store
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    run_op(SSE_OP_STORE_WORD_REG);
    chk("frozen_mem_we", 0, mem_we);
    chk("frozen_mem_addr", 32'h0000_1000, mem_addr);
    @(posedge core_clk_in);
    ce_in <= 1'b1;
    // return, two idle cycles, then its slot
    ta = 32'h0000_0100;
    ti = 16'hFFF0;
    run_op(SSE_OP_RET_SUBROUTINE);
    chk("pc_target", 32'h0000_00F0, pc_target);
    chk("pc_load", 0, pc_load);
    @(posedge core_clk_in);
    #1;
    chk("ret_pending", 1, ret_pend);
    run_op(SSE_OP_REG_EXCLUSIVE_OR);
    chk("pc_load", 1, pc_load);
    chk("slot_result", ta ^ tb, dest_data);
    // return with its slot on the very next edge
    @(posedge core_clk_in);
    drive(SSE_OP_RET_SUBROUTINE);
    issue_in <= 1'b1;
    @(posedge core_clk_in);
    drive(SSE_OP_HALF_SIGN_EXTEND);
    #1;
    chk("ret_pending", 1, ret_pend);
    @(posedge core_clk_in);
    issue_in <= 1'b0;
    #1;
    chk("pc_load", 1, pc_load);
    chk("ret_pending", 0, ret_pend);
    stop_test();
  end
endmodule : testbench
